// *** pkg/plrs_cfg.svh ***
`ifndef PLRS_CFG_SVH
`define PLRS_CFG_SVH

// phy control pair states, bit0 is the lower bit
`define PLRS_CTL_IDLE      2'h0
`define PLRS_CTL_STATUS    2'h1
`define PLRS_CTL_RECEIVE   2'h2
`define PLRS_CTL_GRANT     2'h3

// request type codes
`define PLRS_TYPE_IMM_ACK  3'h0
`define PLRS_TYPE_ISO      3'h1
`define PLRS_TYPE_PRIORITY 3'h2
`define PLRS_TYPE_FAIR     3'h3
`define PLRS_TYPE_REG_RD   3'h4
`define PLRS_TYPE_REG_WR   3'h5

// speed codes
`define PLRS_SPD_100       2'h0
`define PLRS_SPD_200       2'h1
`define PLRS_SPD_400       2'h2
`define PLRS_SPD_RSVD      2'h3

// stream lengths
`define PLRS_LEN_BUS       5'h07
`define PLRS_LEN_REG_RD    5'h09
`define PLRS_LEN_REG_WR    5'h11
`define PLRS_STATUS_BITS   5'h10
`define PLRS_STATUS_SHORT  5'h04

// register byte offsets
`define PLRS_OFS_CTRL      8'h00
`define PLRS_OFS_REQ       8'h04
`define PLRS_OFS_STAT      8'h08
`define PLRS_OFS_PHYREG    8'h0C

// control register fields and reset value
`define PLRS_CTRL_CM_BIT   0
`define PLRS_CTRL_SPD_LSB  1
`define PLRS_CTRL_RESET    3'h0

// request register fields
`define PLRS_REQ_TYPE_LSB  0
`define PLRS_REQ_SPD_LSB   3
`define PLRS_REQ_ADDR_LSB  5
`define PLRS_REQ_DATA_LSB  9
`define PLRS_REQ_PEND_BIT  31

// status register fields and phy register valid bit
`define PLRS_STAT_PEND     0
`define PLRS_STAT_SENT     1
`define PLRS_STAT_RDPEND   2
`define PLRS_STAT_ISO      3
`define PLRS_STAT_LOST     4
`define PLRS_STAT_REFUSED  5
`define PLRS_STAT_FLAGLSB  6
`define PLRS_PHYREG_VALID  16

// timing
`define PLRS_CLK_PERIOD_NS 40
`define PLRS_CRC_WAIT_NS   160
`define PLRS_CRC_WAIT_CYC  \
	((`PLRS_CRC_WAIT_NS + `PLRS_CLK_PERIOD_NS - 1) / `PLRS_CLK_PERIOD_NS)

`endif

// *** pkg/plrs_pkg.sv ***
`default_nettype none
package plrs_pkg;
	typedef enum logic [1:0] {SRC_NONE, SRC_ACK, SRC_CM, SRC_SW} plrs_src_t;
	typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_WAIT} plrs_rx_t;
endpackage
`default_nettype wire

// *** design/plrs_link_request.sv ***
`timescale 1ns/1ps
`include "plrs_cfg.svh"
`default_nettype none
module plrs_link_request
(
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        phyLinkControlBit0In,
	input  wire logic        phyLinkControlBit1In,
	output logic             phyLinkControlBit0Out,
	output logic             phyLinkControlBit1Out,
	output logic             phyLinkControlBit0Oe_b,
	output logic             phyLinkControlBit1Oe_b,
	input  wire logic [1:0]  phyLinkDataLines,
	output logic             linkRequestLine,
	input  wire logic        cycleStartSeen,
	input  wire logic        cycleStartDue,
	input  wire logic        ackWanted,
	input  wire logic        headerCrcBad,
	output logic             busGrant,
	output logic             ackGrant
);
	localparam logic [2:0] CRC_WAIT = 3'(`PLRS_CRC_WAIT_CYC);

	logic [1:0]  ctlMeta_reg;
	logic [1:0]  ctl_reg;
	logic [1:0]  dataMeta_reg;
	logic [1:0]  data_reg;
	logic        ctlWasIdle_reg;
	logic [2:0]  ctrl_reg;
	logic        swPend_reg;
	logic [2:0]  swType_reg;
	logic [1:0]  swSpd_reg;
	logic [3:0]  swAddr_reg;
	logic [7:0]  swData_reg;
	logic        cmPend_reg;
	logic        ackPend_reg;
	logic        sent_reg;
	plrs_pkg::plrs_src_t src_reg;
	logic [16:0] shift_reg;
	logic [4:0]  left_reg;
	logic        link_request_line_reg;
	logic        isoArmed_reg;
	logic        readPend_reg;
	logic        lost_reg;
	logic        refused_reg;
	logic [2:0]  holdoff_reg;
	logic        release_reg;
	logic        busGrant_reg;
	logic        ackGrant_reg;
	plrs_pkg::plrs_rx_t rxState_reg;
	logic [15:0] rxShift_reg;
	logic [4:0]  rxCount_reg;
	logic [3:0]  statFlags_reg;
	logic [11:0] phyReg_reg;
	logic        phyRegValid_reg;

	logic        wrEn;
	logic        rdEn;
	logic        mapped;
	logic [7:0]  ofs;
	logic        idleReady;
	logic        receiving;
	logic        granted;
	logic        serFree;
	logic        launchAck;
	logic        launchCm;
	logic        launchSw;
	logic        swIsReg;
	logic        swIsIso;
	logic        swBadType;
	logic        lostNow;
	logic [16:0] frame;
	logic [4:0]  frameLen;
	logic [2:0]  launchType;
	logic [1:0]  launchSpd;
	logic [15:0] rxWord;

	// pins cross from the phy side through two flops each
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctlMeta_reg  <= 2'h0;
			ctl_reg      <= 2'h0;
			dataMeta_reg <= 2'h0;
			data_reg     <= 2'h0;
		end
		else
		begin
			ctlMeta_reg  <= {phyLinkControlBit1In, phyLinkControlBit0In};
			ctl_reg      <= ctlMeta_reg;
			dataMeta_reg <= phyLinkDataLines;
			data_reg     <= dataMeta_reg;
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			ctlWasIdle_reg <= 1'b0;
		else
			ctlWasIdle_reg <= (ctl_reg == `PLRS_CTL_IDLE);
	end

	// idle must have been seen a clock earlier, not merely now
	assign idleReady = ctlWasIdle_reg && (ctl_reg == `PLRS_CTL_IDLE);
	assign receiving = (ctl_reg == `PLRS_CTL_RECEIVE);
	assign granted   = (ctl_reg == `PLRS_CTL_GRANT) && sent_reg;
	assign serFree   = (left_reg == 5'h00) && (holdoff_reg == 3'h0);

	assign swIsReg = (swType_reg == `PLRS_TYPE_REG_RD) ||
		(swType_reg == `PLRS_TYPE_REG_WR);
	assign swIsIso = (swType_reg == `PLRS_TYPE_ISO);

	// software may not ask for immediate ack or reserved codes
	assign swBadType = (pwdata[2:0] == `PLRS_TYPE_IMM_ACK) ||
		(pwdata[2:0] > `PLRS_TYPE_REG_WR) ||
		(pwdata[4:3] == `PLRS_SPD_RSVD);

	// ack wins: it only has a point while the packet still arrives
	assign launchAck = serFree && ackPend_reg && receiving && !sent_reg;
	assign launchCm  = serFree && !launchAck && cmPend_reg && !sent_reg &&
		idleReady;
	assign launchSw  = serFree && !launchAck && !launchCm && swPend_reg &&
		(swIsReg || (!sent_reg && (swIsIso ? isoArmed_reg : idleReady)));

	assign lostNow = sent_reg && receiving &&
		(src_reg == plrs_pkg::SRC_CM || (src_reg == plrs_pkg::SRC_SW &&
		!swIsIso));

	always_comb
	begin
		launchType = swType_reg;
		launchSpd  = swSpd_reg;
		if (launchAck)
		begin
			launchType = `PLRS_TYPE_IMM_ACK;
			launchSpd  = ctrl_reg[`PLRS_CTRL_SPD_LSB +: 2];
		end
		else if (launchCm)
		begin
			launchType = `PLRS_TYPE_PRIORITY;
			launchSpd  = ctrl_reg[`PLRS_CTRL_SPD_LSB +: 2];
		end
	end

	// first bit to go sits at the top; fields go out msb first
	always_comb
	begin
		case (launchType)
			`PLRS_TYPE_REG_WR:
			begin
				frame    = {1'b1, launchType, swAddr_reg, swData_reg, 1'b0};
				frameLen = `PLRS_LEN_REG_WR;
			end
			`PLRS_TYPE_REG_RD:
			begin
				frame    = {1'b1, launchType, swAddr_reg, 1'b0, 8'h00};
				frameLen = `PLRS_LEN_REG_RD;
			end
			default:
			begin
				frame    = {1'b1, launchType, launchSpd, 1'b0, 10'h000};
				frameLen = `PLRS_LEN_BUS;
			end
		endcase
	end

	// serial request output, one bit per edge, low when idle
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			shift_reg <= 17'h00000;
			left_reg  <= 5'h00;
			link_request_line_reg  <= 1'b0;
		end
		else if (launchAck || launchCm || launchSw)
		begin
			link_request_line_reg  <= frame[16];
			shift_reg <= {frame[15:0], 1'b0};
			left_reg  <= frameLen - 5'h01;
		end
		else if (left_reg != 5'h00)
		begin
			link_request_line_reg  <= shift_reg[16];
			shift_reg <= {shift_reg[15:0], 1'b0};
			left_reg  <= left_reg - 5'h01;
		end
		else
			link_request_line_reg <= 1'b0;
	end

	// a bus request stays outstanding until granted or lost; an ack request until granted or idle
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sent_reg <= 1'b0;
			src_reg  <= plrs_pkg::SRC_NONE;
		end
		else if (launchAck || launchCm || (launchSw && !swIsReg))
		begin
			sent_reg <= 1'b1;
			src_reg  <= launchAck ? plrs_pkg::SRC_ACK :
				(launchCm ? plrs_pkg::SRC_CM : plrs_pkg::SRC_SW);
		end
		else if (granted || lostNow)
		begin
			sent_reg <= 1'b0;
			src_reg  <= plrs_pkg::SRC_NONE;
		end
		else if (src_reg == plrs_pkg::SRC_ACK && ctl_reg == `PLRS_CTL_IDLE)
		begin
			sent_reg <= 1'b0;
			src_reg  <= plrs_pkg::SRC_NONE;
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			ackPend_reg <= 1'b0;
		else if (ackWanted)
			ackPend_reg <= 1'b1;
		else if (launchAck || !receiving)
			ackPend_reg <= 1'b0;
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			cmPend_reg <= 1'b0;
		else if (cycleStartDue && ctrl_reg[`PLRS_CTRL_CM_BIT])
			cmPend_reg <= 1'b1;
		else if (granted && src_reg == plrs_pkg::SRC_CM)
			cmPend_reg <= 1'b0;
	end

	// armed by a cycle start, disarmed by the fair gap ending the cycle
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			isoArmed_reg <= 1'b0;
		else if (cycleStartSeen)
			isoArmed_reg <= 1'b1;
		else if (rxState_reg == plrs_pkg::RX_SHIFT &&
			rxCount_reg == `PLRS_STATUS_SHORT && rxShift_reg[2])
			isoArmed_reg <= 1'b0;
	end

	// bad crc: drive idle once to give the grant back, then keep quiet
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			release_reg  <= 1'b0;
			holdoff_reg  <= 3'h0;
			busGrant_reg <= 1'b0;
			ackGrant_reg <= 1'b0;
		end
		else
		begin
			release_reg  <= granted && src_reg == plrs_pkg::SRC_ACK &&
				headerCrcBad;
			busGrant_reg <= granted && src_reg != plrs_pkg::SRC_ACK;
			ackGrant_reg <= granted && src_reg == plrs_pkg::SRC_ACK &&
				!headerCrcBad;
			if (granted && src_reg == plrs_pkg::SRC_ACK && headerCrcBad)
				holdoff_reg <= CRC_WAIT;
			else if (holdoff_reg != 3'h0)
				holdoff_reg <= holdoff_reg - 3'h1;
		end
	end

	// status receive: d0 carries the earlier bit of each pair
	assign rxWord = {rxShift_reg[13:0], data_reg[0], data_reg[1]};

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rxState_reg <= plrs_pkg::RX_IDLE;
			rxShift_reg <= 16'h0000;
			rxCount_reg <= 5'h00;
		end
		else
		begin
			case (rxState_reg)
				plrs_pkg::RX_IDLE:
					if (ctl_reg == `PLRS_CTL_STATUS)
					begin
						rxState_reg <= plrs_pkg::RX_SHIFT;
						rxShift_reg <= rxWord;
						rxCount_reg <= 5'h02;
					end
				plrs_pkg::RX_SHIFT:
					if (ctl_reg != `PLRS_CTL_STATUS ||
						rxCount_reg == `PLRS_STATUS_BITS)
					begin
						rxState_reg <= plrs_pkg::RX_WAIT;
						rxCount_reg <= 5'h00;
					end
					else
					begin
						rxShift_reg <= rxWord;
						rxCount_reg <= rxCount_reg + 5'h02;
					end
				plrs_pkg::RX_WAIT:
					if (ctl_reg == `PLRS_CTL_IDLE)
						rxState_reg <= plrs_pkg::RX_IDLE;
				default:
					rxState_reg <= plrs_pkg::RX_IDLE;
			endcase
		end
	end

	// flags latch at four bits; a full word also carries register data
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			statFlags_reg   <= 4'h0;
			phyReg_reg      <= 12'h000;
			phyRegValid_reg <= 1'b0;
		end
		else if (rxState_reg == plrs_pkg::RX_SHIFT &&
			ctl_reg != `PLRS_CTL_RECEIVE)
		begin
			// a short status ends on idle; receive here means it was cut
			if (rxCount_reg == `PLRS_STATUS_SHORT)
				statFlags_reg <= {rxShift_reg[0], rxShift_reg[1],
					rxShift_reg[2], rxShift_reg[3]};
			if (rxCount_reg == `PLRS_STATUS_BITS - 5'h02 &&
				ctl_reg == `PLRS_CTL_STATUS)
			begin
				phyReg_reg      <= {rxWord[11:8], rxWord[7:0]};
				phyRegValid_reg <= 1'b1;
			end
		end
		else if (launchSw && swType_reg == `PLRS_TYPE_REG_RD)
			phyRegValid_reg <= 1'b0;
	end

	// apb slave, no wait states
	assign ofs    = paddr[7:0];
	assign mapped = (paddr[31:8] == 24'h000000) && (ofs[1:0] == 2'h0) &&
		(ofs <= `PLRS_OFS_PHYREG);
	assign wrEn   = psel && penable && pwrite && mapped;
	assign rdEn   = psel && penable && !pwrite && mapped;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			ctrl_reg <= `PLRS_CTRL_RESET;
		else if (wrEn && ofs == `PLRS_OFS_CTRL)
			ctrl_reg <= pwdata[2:0];
	end

	// a new request is only taken once the previous one has cleared
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			swPend_reg <= 1'b0;
			swType_reg <= `PLRS_TYPE_FAIR;
			swSpd_reg  <= `PLRS_SPD_100;
			swAddr_reg <= 4'h0;
			swData_reg <= 8'h00;
		end
		else if (wrEn && ofs == `PLRS_OFS_REQ && !swPend_reg && !swBadType)
		begin
			swPend_reg <= 1'b1;
			swType_reg <= pwdata[`PLRS_REQ_TYPE_LSB +: 3];
			swSpd_reg  <= pwdata[`PLRS_REQ_SPD_LSB +: 2];
			swAddr_reg <= pwdata[`PLRS_REQ_ADDR_LSB +: 4];
			swData_reg <= pwdata[`PLRS_REQ_DATA_LSB +: 8];
		end
		else if ((launchSw && swIsReg) ||
			(granted && src_reg == plrs_pkg::SRC_SW))
			swPend_reg <= 1'b0;
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			readPend_reg <= 1'b0;
		else if (launchSw && swType_reg == `PLRS_TYPE_REG_RD)
			readPend_reg <= 1'b1;
		else if (rxState_reg == plrs_pkg::RX_SHIFT &&
			rxCount_reg == `PLRS_STATUS_BITS - 5'h02 &&
			ctl_reg == `PLRS_CTL_STATUS)
			readPend_reg <= 1'b0;
	end

	// sticky flags, write one to clear; a new event beats the clear
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			lost_reg    <= 1'b0;
			refused_reg <= 1'b0;
		end
		else
		begin
			if (lostNow)
				lost_reg <= 1'b1;
			else if (wrEn && ofs == `PLRS_OFS_STAT &&
				pwdata[`PLRS_STAT_LOST])
				lost_reg <= 1'b0;
			if (wrEn && ofs == `PLRS_OFS_REQ && (swPend_reg || swBadType))
				refused_reg <= 1'b1;
			else if (wrEn && ofs == `PLRS_OFS_STAT &&
				pwdata[`PLRS_STAT_REFUSED])
				refused_reg <= 1'b0;
		end
	end

	always_comb
	begin
		prdata = 32'h00000000;
		if (rdEn)
		begin
			case (ofs)
				`PLRS_OFS_CTRL:
					prdata[2:0] = ctrl_reg;
				`PLRS_OFS_REQ:
				begin
					prdata[16:0] = {swData_reg, swAddr_reg, swSpd_reg,
						swType_reg};
					prdata[`PLRS_REQ_PEND_BIT] = swPend_reg;
				end
				`PLRS_OFS_STAT:
					prdata[9:0] = {statFlags_reg, refused_reg, lost_reg,
						isoArmed_reg, readPend_reg, sent_reg, swPend_reg};
				`PLRS_OFS_PHYREG:
				begin
					prdata[11:0] = phyReg_reg;
					prdata[`PLRS_PHYREG_VALID] = phyRegValid_reg;
				end
				default:
					prdata = 32'h00000000;
			endcase
		end
	end

	assign linkRequestLine        = link_request_line_reg;
	assign phyLinkControlBit0Out  = 1'b0;
	assign phyLinkControlBit1Out  = 1'b0;
	assign phyLinkControlBit0Oe_b = !release_reg;
	assign phyLinkControlBit1Oe_b = !release_reg;
	assign busGrant               = busGrant_reg;
	assign ackGrant               = ackGrant_reg;
endmodule // plrs_link_request
`default_nettype wire

// *** tb/plrs_link_request_chk.sv ***
`timescale 1ns/1ps
`include "plrs_cfg.svh"
`default_nettype none
module plrs_link_request_chk
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic phyLinkControlBit0In,
	input wire logic phyLinkControlBit1In,
	input wire logic phyLinkControlBit0Out,
	input wire logic phyLinkControlBit1Out,
	input wire logic phyLinkControlBit0Oe_b,
	input wire logic phyLinkControlBit1Oe_b,
	input wire logic linkRequestLine,
	input wire logic headerCrcBad,
	input wire logic busGrant,
	input wire logic ackGrant
);
	logic [4:0]  bitCnt;
	logic [16:0] sh;
	logic [2:0]  typReg;
	logic [4:0]  lastIdx;
	logic [1:0]  ctl;
	assign ctl = {phyLinkControlBit1In, phyLinkControlBit0In};
	assign lastIdx = (typReg == `PLRS_TYPE_REG_WR) ? 5'h10 :
		(typReg == `PLRS_TYPE_REG_RD) ? 5'h08 : 5'h06;
	// stream decoder so that checks can name a bit position
	always_ff @(posedge clock or negedge rst_b)
		if (!rst_b)
		begin
			bitCnt <= 5'h00;
			sh     <= 17'h00000;
			typReg <= 3'h0;
		end
		else if (bitCnt != 5'h00 || linkRequestLine)
		begin
			sh     <= {sh[15:0], linkRequestLine};
			bitCnt <= (bitCnt >= 5'h05 && bitCnt == lastIdx) ? 5'h00 :
				bitCnt + 5'h01;
			if (bitCnt == 5'h04)
				typReg <= sh[2:0];
		end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	type_not_reserved_a: assert property (
		bitCnt == 5'h04 |-> sh[2:1] != 2'b11)
		else $error("reserved request type sent");
	speed_not_reserved_a: assert property (
		bitCnt == 5'h06 && !sh[4] |-> sh[1:0] != `PLRS_SPD_RSVD)
		else $error("reserved speed sent");
	stop_bit_low_a: assert property (
		bitCnt >= 5'h05 && bitCnt == lastIdx |-> !linkRequestLine)
		else $error("stop bit not low");
	fair_after_idle_a: assert property (
		bitCnt == 5'h04 && sh[2:1] == 2'b01 |->
		$past(ctl, 7) == `PLRS_CTL_IDLE && $past(ctl, 8) == `PLRS_CTL_IDLE)
		else $error("arbitrated request without idle");
	ack_in_receive_a: assert property (
		bitCnt == 5'h04 && sh[2:0] == 3'h0 |->
		$past(ctl, 7) == `PLRS_CTL_RECEIVE)
		else $error("ack request outside receive");
	bus_grant_a: assert property (
		busGrant |-> $past(ctl, 3) == `PLRS_CTL_GRANT)
		else $error("bus grant without phy grant");
	ack_grant_crc_a: assert property (
		ackGrant |-> $past(ctl, 3) == `PLRS_CTL_GRANT && !$past(headerCrcBad))
		else $error("ack grant wrong");
	release_idle_a: assert property (
		!phyLinkControlBit0Oe_b |-> $past(headerCrcBad) &&
		!phyLinkControlBit0Out && !phyLinkControlBit1Out
		##1 phyLinkControlBit0Oe_b)
		else $error("bad release of grant");
	quiet_after_bad_a: assert property (
		$fell(phyLinkControlBit0Oe_b) && bitCnt == 5'h00 |->
		(!linkRequestLine && !ackGrant) [*3])
		else $error("activity after bad crc");
	oe_pair_match_a: assert property (
		phyLinkControlBit1Oe_b == phyLinkControlBit0Oe_b)
		else $error("control pair enables differ");
endmodule // plrs_link_request_chk
bind plrs_link_request plrs_link_request_chk chk
(
	.clock(clock),
	.rst_b(rst_b),
	.phyLinkControlBit0In(phyLinkControlBit0In),
	.phyLinkControlBit1In(phyLinkControlBit1In),
	.phyLinkControlBit0Out(phyLinkControlBit0Out),
	.phyLinkControlBit1Out(phyLinkControlBit1Out),
	.phyLinkControlBit0Oe_b(phyLinkControlBit0Oe_b),
	.phyLinkControlBit1Oe_b(phyLinkControlBit1Oe_b),
	.linkRequestLine(linkRequestLine),
	.headerCrcBad(headerCrcBad),
	.busGrant(busGrant),
	.ackGrant(ackGrant)
);
`default_nettype wire

// *** tb/plrs_phy_model.sv ***
`timescale 1ns/1ps
`include "plrs_cfg.svh"
`default_nettype none
module plrs_phy_model
(
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        linkRequestLine,
	input  wire logic        rxNow,
	input  wire logic        slow,
	output logic             phy_link_control_bit0,
	output logic             phy_link_control_bit1,
	output logic      [1:0]  dataLines,
	output logic      [16:0] lastReq,
	output logic             reqDone
);
	logic [16:0] sh;
	logic [16:0] nx;
	logic [4:0]  cnt;
	logic [4:0]  lastIdx;
	logic [2:0]  typ;
	logic [1:0]  st;
	logic [15:0] sq;
	logic [15:0] sw;
	logic [3:0]  sCnt;
	logic [3:0]  gCnt;
	logic        sPend;
	logic [7:0]  regs [16];
	assign {phy_link_control_bit1, phy_link_control_bit0} = st;
	assign nx = (cnt == 5'h00) ? 17'h00001 : {sh[15:0], linkRequestLine};
	assign lastIdx = (typ == `PLRS_TYPE_REG_WR) ? 5'h10 :
		(typ == `PLRS_TYPE_REG_RD) ? 5'h08 : 5'h06;
	always_ff @(posedge clock or negedge rst_b)
		if (!rst_b)
		begin
			cnt <= 5'h00;
			st <= `PLRS_CTL_IDLE;
			sPend <= 1'b0;
			gCnt <= 4'h0;
			reqDone <= 1'b0;
			dataLines <= 2'h0;
		end
		else
		begin
			reqDone <= 1'b0;
			dataLines <= ~dataLines; // released lines never keep a stale value
			if (cnt != 5'h00 || linkRequestLine)
			begin
				sh <= nx;
				cnt <= (cnt >= 5'h04 && cnt == lastIdx) ? 5'h00 : cnt + 5'h01;
			end
			if (cnt == 5'h03)
				typ <= nx[2:0];
			if (gCnt > 4'h1 && st == `PLRS_CTL_IDLE)
				gCnt <= gCnt - 4'h1;
			if (rxNow)
			begin
				st <= `PLRS_CTL_RECEIVE;
				sCnt <= 4'h0;
				if (typ[2:1] == 2'b01)
					gCnt <= 4'h0;
			end
			else if (st == `PLRS_CTL_STATUS && sCnt != 4'h8)
			begin
				dataLines <= {sq[14], sq[15]};
				sq <= sq << 2;
				sCnt <= sCnt + 4'h1;
			end
			else if (st == `PLRS_CTL_STATUS)
			begin
				st <= `PLRS_CTL_IDLE;
				sPend <= 1'b0;
			end
			else if (sPend && st == `PLRS_CTL_IDLE)
			begin
				st <= `PLRS_CTL_STATUS;
				dataLines <= {sw[14], sw[15]};
				sq <= sw << 2;
				sCnt <= 4'h1;
			end
			else if (gCnt == 4'h1 && !sPend)
			begin
				st <= `PLRS_CTL_GRANT;
				gCnt <= 4'h0;
			end
			else
				st <= `PLRS_CTL_IDLE;
			if (cnt >= 5'h04 && cnt == lastIdx)
			begin
				reqDone <= 1'b1;
				lastReq <= nx;
				if (typ == `PLRS_TYPE_REG_WR)
					regs[nx[12:9]] <= nx[8:1];
				else if (typ == `PLRS_TYPE_REG_RD)
				begin
					sPend <= 1'b1;
					sw <= {4'h0, nx[4:1], regs[nx[4:1]]};
				end
				else
					gCnt <= (typ == `PLRS_TYPE_IMM_ACK) ? 4'h1 :
						slow ? 4'hF : 4'h2;
			end
		end
endmodule // plrs_phy_model
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`include "plrs_cfg.svh"
`default_nettype none
module testbench;
	logic clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, rxNow = 1'b0, slow = 1'b0, ackWanted = 1'b0;
	logic cycleStartSeen = 1'b0, cycleStartDue = 1'b0, headerCrcBad = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
	logic pready, pslverr, out0, out1, oe0_b, oe1_b, mCtl0, mCtl1, reqDone;
	logic linkRequestLine, busGrant, ackGrant;
	logic [1:0]  dataLines;
	logic [16:0] lastReq;
	int n_errors = 0, checked = 0, cycles = 0;
	// the link wins the control pair only while its enable is low
	wire ctlIn0 = oe0_b ? mCtl0 : out0;
	wire ctlIn1 = oe1_b ? mCtl1 : out1;
	always #20 clock = ~clock;
	plrs_link_request dut (.clock(clock), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.phyLinkControlBit0In(ctlIn0), .phyLinkControlBit1In(ctlIn1),
		.phyLinkControlBit0Out(out0), .phyLinkControlBit1Out(out1),
		.phyLinkControlBit0Oe_b(oe0_b), .phyLinkControlBit1Oe_b(oe1_b),
		.phyLinkDataLines(dataLines), .linkRequestLine(linkRequestLine),
		.cycleStartSeen(cycleStartSeen), .cycleStartDue(cycleStartDue),
		.ackWanted(ackWanted), .headerCrcBad(headerCrcBad),
		.busGrant(busGrant), .ackGrant(ackGrant));
	plrs_phy_model phy (.clock(clock), .rst_b(rst_b),
		.linkRequestLine(linkRequestLine), .rxNow(rxNow), .slow(slow),
		.phy_link_control_bit0(mCtl0), .phy_link_control_bit1(mCtl1), .dataLines(dataLines),
		.lastReq(lastReq), .reqDone(reqDone));
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic regWr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, {24'h0, a}, d, r, e);
	endtask
	task automatic regRd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, {24'h0, a}, 32'h0, r, e);
	endtask
	// grants and done flags are one-cycle pulses, so look every cycle
	task automatic waitFor(input int sel);
		int k;
		k = 0;
		do
		begin
			@(posedge clock);
			#1;
			k++;
		end
		while (k < 400 && !(sel == 0 ? reqDone : sel == 1 ? busGrant :
			sel == 2 ? ackGrant : !oe0_b));
		check(32'(k < 400), 32'h1);
	endtask
	function automatic logic [31:0] busS(input logic [2:0] t,
		input logic [1:0] s);
		return {25'h0, 1'b1, t, s, 1'b0};
	endfunction
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			n_errors++;
			stop_test();
		end
	end
	initial
	begin
		logic [31:0] v;
		logic        e;
		logic [3:0]  a;
		logic [7:0]  d;
		void'($urandom(32'h7304));
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		regRd(`PLRS_OFS_CTRL, v);
		check(v, {29'h0, `PLRS_CTRL_RESET});
		apb(1'b0, 32'h10, 32'h0, v, e);
		check({31'h0, e}, 32'h1);
		for (int i = 0; i < 4; i++)
		begin
			a = 4'($urandom);
			d = 8'($urandom);
			regWr(`PLRS_OFS_REQ, {15'h0, d, a, 2'h0, `PLRS_TYPE_REG_WR});
			waitFor(0);
			check({15'h0, lastReq}, {15'h0, 1'b1, 3'h5, a, d, 1'b0});
			regWr(`PLRS_OFS_REQ, {23'h0, a, 2'h0, `PLRS_TYPE_REG_RD});
			waitFor(0);
			check({15'h0, lastReq}, {23'h0, 1'b1, 3'h4, a, 1'b0});
			@(posedge clock);
			rxNow <= i[0]; // odd rounds cut the status short
			repeat (3) @(posedge clock);
			rxNow <= 1'b0;
			v = 32'h4;
			for (int k = 0; k < 40 && v[2]; k++)
				regRd(`PLRS_OFS_STAT, v);
			regRd(`PLRS_OFS_PHYREG, v);
			check(v, {15'h0, 1'b1, 4'h0, a, d});
		end
		for (int j = 0; j < 4; j++)
		begin
			regWr(`PLRS_OFS_REQ, j == 3 ? 32'h0 : j == 2 ? 32'h1B :
				32'(6 + j));
			regRd(`PLRS_OFS_STAT, v);
			check(v & 32'h3F, 32'h20);
			regWr(`PLRS_OFS_STAT, 32'h20);
		end
		for (int t = 1; t < 4; t++)
			for (int s = 0; s < 3; s++)
			begin
				@(posedge clock);
				cycleStartSeen <= (t == 1);
				slow <= 1'($urandom);
				@(posedge clock);
				cycleStartSeen <= 1'b0;
				regWr(`PLRS_OFS_REQ, {27'h0, 2'(s), 3'(t)});
				waitFor(0);
				check({15'h0, lastReq}, busS(3'(t), 2'(s)));
				waitFor(1);
			end
		@(posedge clock);
		slow <= 1'b1;
		regWr(`PLRS_OFS_REQ, {27'h0, `PLRS_SPD_200, `PLRS_TYPE_FAIR});
		waitFor(0);
		@(posedge clock);
		rxNow <= 1'b1;
		repeat (4) @(posedge clock);
		rxNow <= 1'b0;
		waitFor(0);
		check({15'h0, lastReq}, busS(3'h3, 2'h1));
		waitFor(1);
		regRd(`PLRS_OFS_STAT, v);
		check(32'(v[4]), 32'h1);
		regWr(`PLRS_OFS_STAT, 32'h10);
		regWr(`PLRS_OFS_CTRL, 32'h5);
		@(posedge clock);
		cycleStartDue <= 1'b1;
		@(posedge clock);
		cycleStartDue <= 1'b0;
		waitFor(0);
		check({15'h0, lastReq}, busS(3'h2, 2'h2));
		waitFor(1);
		for (int b = 0; b < 2; b++)
		begin
			@(posedge clock);
			rxNow <= 1'b1;
			headerCrcBad <= b[0];
			repeat (3) @(posedge clock);
			ackWanted <= 1'b1;
			@(posedge clock);
			ackWanted <= 1'b0;
			waitFor(0);
			check({15'h0, lastReq}, busS(3'h0, 2'h2));
			@(posedge clock);
			rxNow <= 1'b0;
			waitFor(b == 1 ? 3 : 2);
		end
		repeat (8) @(posedge clock);
		stop_test();
	end
endmodule // testbench
`default_nettype wire
